// ===== apfm_pkg.sv
/*
 * Shared constants for the serial audio port format and monitor block:
 * register offsets, field positions, reset values, codes and timing counts.
 * Assumes a 100 MHz system clock and a host that drives the serial clocks.
 */
// Notes on behaviour
// RQ1: The two-bit format field picks I2S, DSP/TDM, right- or left-justified framing.
// RQ2: The word length field picks 16, 20, 24 or 32 bits for codes 00 to 11.
// RQ3: A frame clock high pulse under eight bit clocks is flagged by pulse option 01.
// RQ4: The data offset counts bit clocks from frame start to the first wanted bit.
// RQ5: The offset is nine bits, format bit 7 on top of the eight-bit low register.
// RQ6: Offset zero means no shift and each step delays the sample by one bit clock.
// RQ7: The first path takes zero, received channel 1 or channel 2 for 00, 01, 10.
// RQ8: The second path takes zero, received channel 2 or channel 1 for 00, 01, 10.
// RQ9: The rate monitor shows a four-bit code, zero for a rate error.
// RQ10: The ten-bit ratio splits into bits 5 to 4 of the rate monitor and the next byte.
// RQ11: The ratio counts bit clocks per frame within 32 to 512 times the sample rate.
// RQ12: The format register reads 02h after reset.
// RQ13: The routing register reads 11h after reset.
// RQ14: The bit clock is valid only when its ratio is stable and within 32 to 512.
// RQ15: Frame clock and data change on the falling bit clock edge unless inverted.
// RQ16: The monitor registers ignore writes and follow the latest detection.
// RQ17: Left-justified MSB starts at the frame edge, right-justified LSB ends the half.
package apfm_pkg;
   // register offsets
   localparam logic [7:0] FMT_ADDR = 8'h33;
   localparam logic [7:0] OFS_ADDR = 8'h34;
   localparam logic [7:0] ROUTE_ADDR = 8'h35;
   localparam logic [7:0] RATE_ADDR = 8'h37;
   localparam logic [7:0] RATIO_ADDR = 8'h38;
   localparam logic [7:0] FLAGS_ADDR = 8'h39;
   // reset values
   localparam logic [7:0] FMT_RST = 8'h02;
   localparam logic [7:0] OFS_RST = 8'h00;
   localparam logic [7:0] ROUTE_RST = 8'h11;
   // field positions
   localparam int unsigned OFS_MSB_POS = 7;
   localparam int unsigned FMT_POS = 4;
   localparam int unsigned PULSE_POS = 2;
   localparam int unsigned WLEN_POS = 0;
   localparam int unsigned ROUTE1_POS = 4;
   localparam int unsigned ROUTE2_POS = 0;
   // frame formats and options
   localparam logic [1:0] FMT_I2S = 2'h0;
   localparam logic [1:0] FMT_DSP = 2'h1;
   localparam logic [1:0] FMT_RJ = 2'h2;
   localparam logic [1:0] FMT_LJ = 2'h3;
   localparam logic [1:0] PULSE_SHORT = 2'h1;
   localparam logic [1:0] ROUTE_OWN = 2'h1;
   localparam logic [1:0] ROUTE_OTHER = 2'h2;
   // word lengths in bits
   localparam logic [5:0] WLEN_16 = 6'h10;
   localparam logic [5:0] WLEN_20 = 6'h14;
   localparam logic [5:0] WLEN_24 = 6'h18;
   localparam logic [5:0] WLEN_32 = 6'h20;
   // detected rate codes
   localparam logic [3:0] RATE_ERR = 4'h0;
   localparam logic [3:0] RATE_8K = 4'h2;
   localparam logic [3:0] RATE_16K = 4'h4;
   localparam logic [3:0] RATE_32K = 4'h6;
   localparam logic [3:0] RATE_48K = 4'h9;
   localparam logic [3:0] RATE_96K = 4'hB;
   // ratio limits in bit clocks per frame
   localparam logic [9:0] RATIO_MIN = 10'h020;
   localparam logic [9:0] RATIO_MAX = 10'h200;
   // data path sizes
   localparam int unsigned WORD_W = 32;
   localparam int unsigned FIFO_DEPTH = 16;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned CLK_HZ = 1000000000 / CLK_PERIOD_NS;
   localparam int unsigned PER_8K = CLK_HZ / 8000;
   localparam int unsigned PER_16K = CLK_HZ / 16000;
   localparam int unsigned PER_32K = CLK_HZ / 32000;
   localparam int unsigned PER_48K = CLK_HZ / 48000;
   localparam int unsigned PER_96K = CLK_HZ / 96000;
   localparam int unsigned PER_TOL_SHIFT = 5;
   localparam int unsigned MISS_TIME_US = 1000;
   localparam int unsigned MISS_CYC_DEF = MISS_TIME_US * 1000 / CLK_PERIOD_NS;
endpackage

// ===== apfm_stream_if.sv
/*
 * Valid/ready stream carrier between the block and its sample FIFO.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface apfm_stream_if #(parameter int unsigned W = 64);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ===== apfm_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes writer and reader run on the same clock and reset.
 */
`timescale 1ns/1ps
module apfm_fifo #(
   parameter int unsigned W = 64,
   parameter int unsigned DEPTH = 16
) (
   // system
   input wire logic clk_in,
   input wire logic rst_n_in,
   // streams
   apfm_stream_if.snk wr,
   apfm_stream_if.src rd
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   // honest flags: full stalls the writer, empty hides data
   assign wr.ready = (count_reg != (AW+1)'(DEPTH));
   assign rd.valid = (count_reg != '0);
   assign rd.data = mem[rd_ptr_reg];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;

   // storage needs no reset, only pointers and count do
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr_reg] <= wr.data;
      end
   end

   // pointers wrap at depth
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ===== apfm_top.sv
/*
 * Serial audio port: frame format registers, sample capture on the bit
 * clock, per-path routing, rate and ratio monitors, clock flags.
 * Assumes the host drives bit clock, frame clock and data; the bit clock
 * may stop between streams.
 */
`timescale 1ns/1ps
module apfm_top #(
   parameter int unsigned MISS_CYC = apfm_pkg::MISS_CYC_DEF
) (
   // system
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wr_data_in,
   output logic [7:0] reg_rd_data_out,
   // serial link
   input wire logic bit_clk_in,
   input wire logic frame_clk_in,
   input wire logic serial_data_in,
   input wire logic bit_clock_invert_in,
   // routed sample stream
   output logic [apfm_pkg::WORD_W-1:0] first_path_data_out,
   output logic [apfm_pkg::WORD_W-1:0] second_path_data_out,
   output logic sample_valid_out,
   input wire logic sample_ready_in,
   output logic sample_accept_out
);
   import apfm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [5:0] wlen_bits(input logic [1:0] code);
      unique case (code)
         2'h0: wlen_bits = WLEN_16;
         2'h1: wlen_bits = WLEN_20;
         2'h2: wlen_bits = WLEN_24;
         2'h3: wlen_bits = WLEN_32;
      endcase
   endfunction

   function automatic logic [31:0] route(input logic [1:0] sel,
                                         input logic [31:0] own,
                                         input logic [31:0] other);
      if (sel == ROUTE_OWN) route = own;
      else if (sel == ROUTE_OTHER) route = other;
      else route = '0; // zero data, reserved code also mutes
   endfunction

   function automatic logic near(input logic [16:0] p, input int unsigned per);
      near = (32'(p) >= per - (per >> PER_TOL_SHIFT)) &&
             (32'(p) <= per + (per >> PER_TOL_SHIFT));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register file (system clock)

   logic [7:0] fmt_reg;
   logic [7:0] ofs_reg;
   logic [7:0] route_reg;
   logic [3:0] rate_mon_reg;
   logic [9:0] ratio_mon_reg;
   logic [7:0] flags;
   logic [7:0] rd_data_reg;

   // only the three control registers take writes; monitors ignore them
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         fmt_reg <= FMT_RST; // RQ12
         ofs_reg <= OFS_RST;
         route_reg <= ROUTE_RST; // RQ13
      end else if (reg_wr_in) begin
         if (reg_addr_in == FMT_ADDR) fmt_reg <= reg_wr_data_in;
         if (reg_addr_in == OFS_ADDR) ofs_reg <= reg_wr_data_in; // RQ5
         if (reg_addr_in == ROUTE_ADDR) route_reg <= reg_wr_data_in;
      end
   end

   // read data one cycle after the address, unmapped reads zero
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         rd_data_reg <= 8'h00;
      end else begin
         unique case (reg_addr_in)
            FMT_ADDR: rd_data_reg <= fmt_reg;
            OFS_ADDR: rd_data_reg <= ofs_reg;
            ROUTE_ADDR: rd_data_reg <= route_reg;
            RATE_ADDR: rd_data_reg <= {2'h0, ratio_mon_reg[9:8], rate_mon_reg}; // RQ10
            RATIO_ADDR: rd_data_reg <= ratio_mon_reg[7:0]; // RQ10
            FLAGS_ADDR: rd_data_reg <= flags;
            default: rd_data_reg <= 8'h00;
         endcase
      end
   end
   assign reg_rd_data_out = rd_data_reg;

   ////////////////////////////////////////////////////////////////////////
   // link domain: reset and configuration crossing

   logic lrst_s1_reg;
   logic lrst_n_reg;
   logic [16:0] cfg_s1_reg;
   logic [16:0] cfg_s2_reg;

   // reset and static config pass two bit-clock flops; config is
   // expected to be written while the stream is idle
   always_ff @(posedge bit_clk_in) begin
      lrst_s1_reg <= rst_n_in;
      lrst_n_reg <= lrst_s1_reg;
      cfg_s1_reg <= {bit_clock_invert_in, fmt_reg, ofs_reg};
      cfg_s2_reg <= cfg_s1_reg;
   end

   logic l_inv;
   logic [1:0] l_fmt;
   logic [1:0] l_pulse;
   logic [5:0] l_wlen;
   logic [8:0] l_ofs;
   assign l_inv = cfg_s2_reg[16];
   assign l_fmt = cfg_s2_reg[8 + FMT_POS +: 2]; // RQ1
   assign l_pulse = cfg_s2_reg[8 + PULSE_POS +: 2];
   assign l_wlen = wlen_bits(cfg_s2_reg[8 + WLEN_POS +: 2]); // RQ2
   assign l_ofs = {cfg_s2_reg[8 + OFS_MSB_POS], cfg_s2_reg[7:0]}; // RQ5

   ////////////////////////////////////////////////////////////////////////
   // link domain: edge selection and framing

   logic fall_lr_reg;
   logic fall_dat_reg;
   logic lr;
   logic dat;

   // inverted mode: host changes on the rising edge, so sample on the fall
   always_ff @(negedge bit_clk_in) begin
      fall_lr_reg <= frame_clk_in;
      fall_dat_reg <= serial_data_in;
   end
   assign lr = l_inv ? fall_lr_reg : frame_clk_in; // RQ15
   assign dat = l_inv ? fall_dat_reg : serial_data_in; // RQ15

   logic lr_prev_reg;
   logic [9:0] cnt_reg;
   logic [9:0] ratio_hold_reg;
   logic frame_start;
   logic [9:0] pos;

   // i2s frames open on the falling frame clock, the rest on the rise
   assign frame_start = (lr != lr_prev_reg) && ((l_fmt == FMT_I2S) ? !lr : lr); // RQ1
   assign pos = frame_start ? 10'h000 : cnt_reg;

   // bit counter saturates so a stuck frame clock reads out of range
   always_ff @(posedge bit_clk_in) begin
      if (!lrst_n_reg) begin
         lr_prev_reg <= 1'b0;
         cnt_reg <= 10'h000;
         ratio_hold_reg <= 10'h000;
      end else begin
         lr_prev_reg <= lr;
         if (cnt_reg != 10'h3FF || frame_start) cnt_reg <= pos + 10'h001;
         if (frame_start) ratio_hold_reg <= cnt_reg; // RQ11
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link domain: slot placement and capture

   logic [10:0] half;
   logic [10:0] ch1_st;
   logic [10:0] ch2_st;
   logic in1;
   logic in2;

   // a short pulse marks no half frame, so slots pack back to back
   always_comb begin
      half = {2'h0, ratio_hold_reg[9:1]};
      ch1_st = {2'h0, l_ofs}; // RQ4 RQ6
      ch2_st = {2'h0, l_ofs} + {5'h00, l_wlen};
      if (l_pulse != PULSE_SHORT && l_fmt != FMT_DSP) begin // RQ3
         unique case (l_fmt)
            FMT_I2S: begin
               ch1_st = {2'h0, l_ofs} + 11'h001;
               ch2_st = half + {2'h0, l_ofs} + 11'h001;
            end
            FMT_RJ: begin // RQ17
               ch1_st = half - {5'h00, l_wlen} + {2'h0, l_ofs};
               ch2_st = {1'b0, ratio_hold_reg} - {5'h00, l_wlen} + {2'h0, l_ofs};
            end
            default: begin // RQ17
               ch2_st = half + {2'h0, l_ofs};
            end
         endcase
      end
   end
   assign in1 = ({1'b0, pos} >= ch1_st) && ({1'b0, pos} < ch1_st + {5'h00, l_wlen});
   assign in2 = ({1'b0, pos} >= ch2_st) && ({1'b0, pos} < ch2_st + {5'h00, l_wlen});

   logic [31:0] sh1_reg;
   logic [31:0] sh2_reg;
   logic [31:0] base1;
   logic [31:0] base2;
   assign base1 = frame_start ? 32'h0000_0000 : sh1_reg;
   assign base2 = frame_start ? 32'h0000_0000 : sh2_reg;

   // msb first shift into each channel while inside its slot
   always_ff @(posedge bit_clk_in) begin
      if (!lrst_n_reg) begin
         sh1_reg <= 32'h0000_0000;
         sh2_reg <= 32'h0000_0000;
      end else begin
         sh1_reg <= in1 ? {base1[30:0], dat} : base1;
         sh2_reg <= in2 ? {base2[30:0], dat} : base2;
      end
   end

   logic [31:0] word1_reg;
   logic [31:0] word2_reg;
   logic tog_reg;

   // words are left-aligned and held a whole frame, long enough to cross
   always_ff @(posedge bit_clk_in) begin
      if (!lrst_n_reg) begin
         word1_reg <= 32'h0000_0000;
         word2_reg <= 32'h0000_0000;
         tog_reg <= 1'b0;
      end else if (frame_start) begin
         word1_reg <= sh1_reg << (6'h20 - l_wlen); // RQ2
         word2_reg <= sh2_reg << (6'h20 - l_wlen);
         tog_reg <= ~tog_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // system domain: frame event crossing and monitors

   logic tog_s1_reg;
   logic tog_s2_reg;
   logic tog_s3_reg;
   logic evt;

   // toggle crossing; the first flop feeds only the second
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         tog_s3_reg <= 1'b0;
      end else begin
         tog_s1_reg <= tog_reg;
         tog_s2_reg <= tog_s1_reg;
         tog_s3_reg <= tog_s2_reg;
      end
   end
   assign evt = tog_s2_reg ^ tog_s3_reg;

   logic [16:0] per_cnt_reg;
   logic [31:0] miss_cnt_reg;
   logic missing;
   logic ratio_ok_reg;
   assign missing = (miss_cnt_reg >= MISS_CYC);

   // frame period in system clocks and a watchdog for a stopped link
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         per_cnt_reg <= 17'h0_0000;
         miss_cnt_reg <= 32'h0000_0000;
      end else if (evt) begin
         per_cnt_reg <= 17'h0_0001;
         miss_cnt_reg <= 32'h0000_0000;
      end else begin
         if (per_cnt_reg != 17'h1_FFFF) per_cnt_reg <= per_cnt_reg + 17'h0_0001;
         if (!missing) miss_cnt_reg <= miss_cnt_reg + 32'h0000_0001;
      end
   end

   // monitors change only from detection, never from writes
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         rate_mon_reg <= RATE_ERR;
         ratio_mon_reg <= 10'h000;
         ratio_ok_reg <= 1'b0;
      end else if (missing) begin
         rate_mon_reg <= RATE_ERR; // RQ9
         ratio_ok_reg <= 1'b0;
      end else if (evt) begin // RQ16
         ratio_mon_reg <= ratio_hold_reg; // RQ11
         ratio_ok_reg <= (ratio_hold_reg == ratio_mon_reg) &&
                         (ratio_hold_reg >= RATIO_MIN) &&
                         (ratio_hold_reg <= RATIO_MAX); // RQ14
         if (near(per_cnt_reg, PER_8K)) rate_mon_reg <= RATE_8K; // RQ9
         else if (near(per_cnt_reg, PER_16K)) rate_mon_reg <= RATE_16K;
         else if (near(per_cnt_reg, PER_32K)) rate_mon_reg <= RATE_32K;
         else if (near(per_cnt_reg, PER_48K)) rate_mon_reg <= RATE_48K;
         else if (near(per_cnt_reg, PER_96K)) rate_mon_reg <= RATE_96K;
         else rate_mon_reg <= RATE_ERR;
      end
   end
   assign flags = {5'h00, missing, !ratio_ok_reg, rate_mon_reg == RATE_ERR};

   ////////////////////////////////////////////////////////////////////////
   // system domain: routing into the sample FIFO

   apfm_stream_if #(.W(2 * WORD_W)) push_if ();
   apfm_stream_if #(.W(2 * WORD_W)) pop_if ();
   logic push_valid_reg;
   logic [63:0] push_data_reg;

   // a frame that finds the FIFO full is dropped; accept shows the stall
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         push_valid_reg <= 1'b0;
         push_data_reg <= 64'h0;
      end else begin
         push_valid_reg <= evt;
         if (evt) begin
            push_data_reg <= {route(route_reg[ROUTE1_POS +: 2], word1_reg, word2_reg), // RQ7
                              route(route_reg[ROUTE2_POS +: 2], word2_reg, word1_reg)}; // RQ8
         end
      end
   end
   assign push_if.valid = push_valid_reg;
   assign push_if.data = push_data_reg;
   assign pop_if.ready = sample_ready_in;

   apfm_fifo #(.W(2 * WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .wr(push_if),
      .rd(pop_if)
   );
   assign sample_accept_out = push_if.ready;
   assign sample_valid_out = pop_if.valid;
   assign first_path_data_out = pop_if.data[63:32];
   assign second_path_data_out = pop_if.data[31:0];

   ////////////////////////////////////////////////////////////////////////
   // checks

   fmt_reset_a: assert property (@(posedge ref_clk_in) // RQ12
      $rose(rst_n_in) |-> fmt_reg == 8'h02)
      else $error("format register not 02h after reset");
   route_reset_a: assert property (@(posedge ref_clk_in) // RQ13
      $rose(rst_n_in) |-> route_reg == 8'h11)
      else $error("routing register not 11h after reset");
   mon_stable_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ16
      !evt && !missing |=> $stable(ratio_mon_reg) && $stable(rate_mon_reg))
      else $error("monitor changed without detection");
   offset_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ5
      reg_wr_in && reg_addr_in == 8'h34 |=> ofs_reg == $past(reg_wr_data_in))
      else $error("offset low byte not written");
   route_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ7
      evt && route_reg[5:4] == 2'h0 |=> push_valid_reg && push_data_reg[63:32] == 32'h0)
      else $error("first path not muted");
   route_swap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ8
      evt && route_reg[1:0] == 2'h2 |=> push_data_reg[31:0] == $past(word1_reg))
      else $error("second path not fed from channel 1");
   rate_err_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ9
      missing |=> rate_mon_reg == 4'h0 && flags[1])
      else $error("stopped link not reported as rate error");
   ratio_range_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ14
      ratio_ok_reg |-> ratio_mon_reg >= 10'd32 && ratio_mon_reg <= 10'd512)
      else $error("ratio valid outside 32 to 512");
   ratio_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ10
      reg_addr_in == 8'h37 ##1 $stable(ratio_mon_reg)
      |-> reg_rd_data_out[5:4] == ratio_mon_reg[9:8] && reg_rd_data_out[7:6] == 2'h0)
      else $error("ratio high bits misplaced");
endmodule

// ===== apfm_host_model.sv
/* Host audio source: drives bit clock, frame clock and serial data, one frame per queued pair.
   Assumes the bench changes the format inputs only while the link is idle. */
`timescale 1ns/1ps
module apfm_host_model (
   // format from the bench
   input wire logic idle_run_in,
   input wire logic invert_in,
   input wire logic [1:0] fmt_in,
   input wire logic short_in,
   input wire logic [5:0] wlen_in,
   input wire logic [8:0] ofs_in,
   // serial link
   output logic bit_clk_out,
   output logic frame_clk_out,
   output logic data_out
);
   import apfm_pkg::*;
   ////////////////////////////////////////////////////////////
   // 348 bit clocks of 30 ns make a frame close to 96 kHz
   localparam int R = 348;
   logic [63:0] frames[$];
   logic [63:0] w;
   logic clk_raw = 1'b0;
   int first = 0;
   assign bit_clk_out = clk_raw ^ invert_in;
   task automatic queue_frame(input logic [31:0] a, input logic [31:0] b);
      frames.push_back({a, b});
   endtask
   // one bit: change after the falling edge so that the rising edge samples it
   task automatic slot(input int p, input logic [63:0] v);
      int s1, s2, h;
      h = R / 2;
      s1 = ofs_in;
      s2 = ofs_in + wlen_in;
      if (!short_in && fmt_in == FMT_I2S) begin
         s1 = ofs_in + 1;
         s2 = h + ofs_in + 1;
      end else if (!short_in && fmt_in == FMT_LJ) begin
         s2 = h + ofs_in;
      end else if (!short_in && fmt_in == FMT_RJ) begin
         s1 = h - wlen_in + ofs_in;
         s2 = R - wlen_in + ofs_in;
      end
      clk_raw = 1'b0;
      frame_clk_out = (fmt_in == FMT_I2S) ^ (short_in ? p == 0 : p < h);
      if (p >= s1 && p < s1 + wlen_in) data_out = v[63 - p + s1];
      else if (p >= s2 && p < s2 + wlen_in) data_out = v[31 - p + s2];
      else data_out = p[0]; // idle slots toggle so a stale bit never looks valid
      #15 clk_raw = 1'b1;
      #15;
   endtask
   // frames back to back; one more frame start closes the last frame
   initial begin
      frame_clk_out = 1'b1;
      data_out = 1'b0;
      forever begin
         if (frames.size() != 0) begin
            w = frames.pop_front();
            for (int p = first; p < R; p++) slot(p, w);
            first = 0;
            if (frames.size() == 0) begin
               // inverted, the start is taken only on the next rising edge; resume inside the frame
               for (first = 0; first <= int'(invert_in); first++) slot(first, '0);
            end
         end else if (idle_run_in) begin
            first = 0;
            slot(R - 1, '0);
         end else begin
            #5;
         end
      end
   end
endmodule

// ===== testbench.sv
/* Self-checking bench for the audio port block, fed by the host source model.
   Assumes read data follows the address one cycle later. */
`timescale 1ns/1ps
module testbench;
   import apfm_pkg::*;
   ////////////////////////////////////////////////////////////
   logic ref_clk_in, rst_n_in, reg_wr_in, sample_ready_in, sample_valid_out, sample_accept_out;
   logic [7:0] reg_addr_in, reg_wr_data_in, reg_rd_data_out;
   logic [31:0] first_path_data_out, second_path_data_out;
   logic bit_clk, frame_clk, sdata, idle, inv, pulse_short, hold;
   logic [1:0] fmt;
   logic [5:0] wlen;
   logic [8:0] ofs;
   logic [64:0] e;
   logic [64:0] exp_q[$];
   int num_errors = 0;
   int check_count = 0;
   apfm_top #(.MISS_CYC(3000)) i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wr_data_in(reg_wr_data_in),
      .reg_rd_data_out(reg_rd_data_out), .bit_clk_in(bit_clk), .frame_clk_in(frame_clk),
      .serial_data_in(sdata), .bit_clock_invert_in(inv),
      .first_path_data_out(first_path_data_out), .second_path_data_out(second_path_data_out),
      .sample_valid_out(sample_valid_out), .sample_ready_in(sample_ready_in),
      .sample_accept_out(sample_accept_out));
   apfm_host_model i_host (.idle_run_in(idle), .invert_in(inv), .fmt_in(fmt),
      .short_in(pulse_short), .wlen_in(wlen), .ofs_in(ofs), .bit_clk_out(bit_clk),
      .frame_clk_out(frame_clk), .data_out(sdata));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (num_errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      reg_addr_in = a;
      reg_wr_data_in = d;
      reg_wr_in = 1'b1;
      @(negedge ref_clk_in);
      reg_wr_in = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(negedge ref_clk_in);
      reg_addr_in = a;
      @(negedge ref_clk_in);
      check({24'h0, reg_rd_data_out}, {24'h0, x});
   endtask
   // the bit clock idles on through reset and setup: the link resets and takes the new format
   task automatic reset_dut();
      idle = 1'b1;
      rst_n_in = 1'b0;
      exp_q.delete();
      repeat (12) @(negedge ref_clk_in);
      rst_n_in = 1'b1;
   endtask
   task automatic drain();
      for (int i = 0; i < 30000 && exp_q.size() != 0; i++) @(negedge ref_clk_in);
      check(32'(exp_q.size()), 32'h0); // frames that never came out
   endtask
   function automatic logic [31:0] sel(input logic [1:0] c, input logic [31:0] own,
         input logic [31:0] oth);
      return (c == ROUTE_OWN) ? own : (c == ROUTE_OTHER) ? oth : 32'h0;
   endfunction
   // configure while idle, queue frames, note what each path must carry
   task automatic run(input logic [1:0] f, input logic [1:0] wc, input logic [8:0] o,
         input logic s, input logic [7:0] rt, input logic iv, input int n);
      logic [31:0] a, b, m;
      logic [7:0] cfg;
      cfg = {o[8], 1'b0, f, 1'b0, s, wc};
      fmt = f;
      pulse_short = s;
      ofs = o;
      inv = iv;
      wlen = (wc == 2'h0) ? WLEN_16 : (wc == 2'h1) ? WLEN_20 : (wc == 2'h2) ? WLEN_24 : WLEN_32;
      m = ~(32'hFFFFFFFF >> wlen);
      reset_dut();
      wr(FMT_ADDR, cfg);
      wr(OFS_ADDR, o[7:0]);
      wr(ROUTE_ADDR, rt);
      rd(FMT_ADDR, cfg);
      rd(OFS_ADDR, o[7:0]);
      exp_q.push_back({1'b0, 64'h0}); // the opening frame start closes no frame
      for (int i = 0; i < n; i++) begin
         a = $urandom;
         b = $urandom;
         i_host.queue_frame(a, b);
         // opening sample plus 15 frames fill the buffer; half-frame slots learn the length first
         if (i < FIFO_DEPTH - 1) exp_q.push_back({f == FMT_DSP || s || i > 0,
            sel(rt[5:4], a & m, b & m), sel(rt[1:0], b & m, a & m)});
      end
      while (i_host.frames.size() != 0) @(negedge ref_clk_in);
      idle = 1'b0; // the bit clock stops after the closing start
      repeat (1200) @(negedge ref_clk_in);
   endtask
   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   // random back-pressure, with ready held low throughout while the buffer is meant to fill
   always @(negedge ref_clk_in) sample_ready_in <= !hold && ($urandom % 3 != 0);
   // a pop happens at the next rising edge, so compare while the outputs stand
   always @(negedge ref_clk_in) begin
      #1;
      if (rst_n_in === 1'b1 && sample_valid_out === 1'b1 && sample_ready_in === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(32'h1, 32'h0); // a sample nobody sent
         end else begin
            e = exp_q.pop_front();
            if (e[64]) begin
               check(first_path_data_out, e[63:32]);
               check(second_path_data_out, e[31:0]);
            end
         end
      end
   end
   initial begin
      #1000000;
      num_errors++;
      conclude();
   end
   initial begin
      {rst_n_in, reg_wr_in, idle, inv, pulse_short, hold} = 6'h00;
      reg_addr_in = 8'h00;
      reg_wr_data_in = 8'h00;
      fmt = FMT_I2S;
      wlen = WLEN_24;
      ofs = 9'h000;
      void'($urandom(32'hE9C2));
      reset_dut();
      rd(FMT_ADDR, FMT_RST);
      rd(ROUTE_ADDR, ROUTE_RST);
      wr(RATE_ADDR, 8'hFF);
      wr(RATIO_ADDR, 8'hFF);
      rd(RATE_ADDR, 8'h00);
      rd(RATIO_ADDR, 8'h00);
      rd(8'h36, 8'h00); // a gap in the map reads zero
      hold = 1'b1;
      run(FMT_I2S, 2'h2, 9'h000, 1'b0, ROUTE_RST, 1'b0, 18);
      check({31'h0, sample_accept_out}, 32'h0); // full buffer refuses
      rd(RATE_ADDR, {4'h1, RATE_96K});
      rd(RATIO_ADDR, 8'h5C);
      rd(FLAGS_ADDR, 8'h00);
      hold = 1'b0;
      drain();
      repeat (3500) @(negedge ref_clk_in);
      rd(FLAGS_ADDR, 8'h07);
      run(FMT_DSP, 2'h0, 9'h101, 1'b0, 8'h21, 1'b0, 4);
      drain();
      run(FMT_RJ, 2'h1, 9'h000, 1'b0, 8'h02, 1'b0, 4);
      drain();
      run(FMT_LJ, 2'h3, 9'h001, 1'b1, 8'h10, 1'b1, 4);
      drain();
      conclude();
   end
endmodule
